// ==== rtl/mpd_map.vh ====
// register offsets, field positions, reset values and decode constants
`ifndef MPD_MAP_VH
`define MPD_MAP_VH

// register word offsets on the avalon bus (byte address = 4 * index)
`define MPD_IDX_PAGE 8'hE0
`define MPD_IDX_PWR_A 8'hB0
`define MPD_IDX_PWR_B 8'hB4
`define MPD_IDX_JTAG_EN 8'hC7
`define MPD_IDX_DEC_BASE 8'h40
`define MPD_IDX_PORT_CFG 8'h50
`define MPD_IDX_CLA_IN 8'h60
`define MPD_IDX_CLA_OUT 8'h61
`define MPD_IDX_SELECTS 8'h62
`define MPD_IDX_STATUS 8'h63
`define MPD_IDX_APD_LIMIT 8'h64

// reset values
`define MPD_RST_PAGE 8'h00
`define MPD_RST_PWR_A 8'h01
`define MPD_RST_PWR_B 8'h00
`define MPD_RST_JTAG_EN 8'h00
`define MPD_RST_PORT_CFG 8'h00
`define MPD_RST_APD_LIMIT 16'h0100

// power control reg a fields
`define MPD_PA_SPEED 0
`define MPD_PA_APD_EN 1
// power control reg b fields
`define MPD_PB_GATE_STROBE 0
`define MPD_PB_GATE_PORTS 1
`define MPD_PB_GATE_ADDR 2

// port cfg fields
`define MPD_PC_AB_DATA 0
`define MPD_PC_ADDR_OUT 1

// decode select and logic array counts
`define MPD_NUM_PRI 8
`define MPD_NUM_SEC 4
`define MPD_NUM_SEL 17
`define MPD_SEL_SRAM 12
`define MPD_SEL_REGS 13
`define MPD_NUM_IN 24
`define MPD_NUM_OMC 16
`define MPD_NUM_COMB 3

`endif

// ==== rtl/mpd_decode_array.v ====
// combinational address decode array: page + address to block selects
`timescale 1ns/1ps
`default_nettype none
module mpd_decode_array (
    // address inputs
    input wire [7:0] page_i,
    input wire [15:0] addr_i,
    input wire cs_n_i,
    // per-select match patterns: 8 page bits + 4 addr msbs, with care masks
    input wire [203:0] match_i,
    input wire [203:0] care_i,
    // selects
    output reg [16:0] sel_o
);
    integer k;
    reg [11:0] key;

    always @* begin
        key = {page_i, addr_i[15:12]};
        sel_o = 17'h00000;
        for (k = 0; k < 17; k = k + 1) begin
            // memories disabled while chip select is high
            sel_o[k] = ~cs_n_i & (((key ^ match_i[k*12 +: 12])
                & care_i[k*12 +: 12]) == 12'h000);
        end
    end
endmodule // mpd_decode_array
`default_nettype wire

// ==== rtl/mpd_complex_array.v ====
// complex logic array: 16 registered and 3 combinational outputs, sleep
`timescale 1ns/1ps
`default_nettype none
module mpd_complex_array (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // logic input bus and control
    input wire [31:0] in_bus_i,
    input wire speed_i,
    input wire load_i,
    input wire [15:0] load_data_i,
    // outputs
    output reg [15:0] omc_o,
    output reg [2:0] comb_o,
    output reg asleep_o
);
    reg [31:0] prev_reg;
    wire changed = (in_bus_i != prev_reg);
    wire [15:0] term = in_bus_i[15:0] ^ in_bus_i[31:16];

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_reg <= 32'h00000000;
            omc_o <= 16'h0000;
            asleep_o <= 1'b0;
        end else begin
            prev_reg <= in_bus_i;
            if (load_i) begin
                omc_o <= load_data_i;
            end else if (speed_i || changed) begin
                omc_o <= term;
            end
            // sleep until the next input transition
            asleep_o <= ~speed_i & ~changed;
        end
    end

    always @* begin
        comb_o = {^in_bus_i[31:16], &in_bus_i[7:0], |in_bus_i[15:8]};
    end
endmodule // mpd_complex_array
`default_nettype wire

// ==== rtl/mpd_top.v ====
// peripheral top: avalon registers, decode, complex array, ports, power
//
// Summary of operation
// - 8-bit page register extends address
// - page rewrite remaps flash sectors
// - eight independent primary flash sector selects
// - four independent secondary flash sector selects
// - decode selects are combinational, registered once at sel_o
// - sixteen registered plus three combinational outputs
// - 24 input macrocells feed logic bus
// - control strobes fed undecoded to bus
// - speed bit low: array sleeps
// - gating bits freeze array inputs
// - bus inactivity triggers automatic power down
// - 27 pins, function select per port group
// - port A as data bus, port B outputs disabled
// - JTAG takes over port C pins
// - programmer programs all without microcontroller
// - chip select high disables memories
// - logic clock drives array and counter
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mpd_map.vh"
module mpd_top (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // avalon-mm slave
    input wire [9:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // microcontroller bus
    input wire [15:0] mcu_addr_i,
    input wire mcu_rd_n_i,
    input wire mcu_wr_n_i,
    input wire mcu_ale_i,
    input wire mcu_cs_n_i,
    // port pins a,b (8), c (8 less bit 2 unused), d (3)
    input wire [26:0] pin_in_i,
    output reg [26:0] pin_out_o,
    output reg [26:0] pin_oe_o,
    // jtag on port c
    input wire jtag_tdo_i,
    input wire jtag_test_status_out_i,
    input wire jtag_test_error_out_i,
    output reg jtag_tms_o,
    output reg jtag_tck_o,
    output reg jtag_tdi_o,
    // selects and status
    output reg [16:0] sel_o,
    output reg powered_down_o,
    output reg [7:0] mcu_data_out_o
);
    ////////////////////////////////////////////////////////////////////////
    // registers
    reg [7:0] page_reg;
    reg [7:0] pwr_a_reg;
    reg [7:0] pwr_b_reg;
    reg [7:0] jtag_en_reg;
    reg [7:0] port_cfg_reg;
    reg [15:0] apd_limit_reg;
    reg [203:0] match_reg;
    reg [203:0] care_reg;
    reg [23:0] imc_reg;
    reg [15:0] mcu_latch_reg;
    reg [15:0] apd_cnt_reg;
    reg [3:0] prev_strobe_reg;
    reg [31:0] gated_reg;
    reg ack_reg;
    reg cla_load_reg;
    reg [15:0] cla_load_data_reg;

    wire [7:0] idx = avs_address_i[9:2];
    wire [16:0] dec_sel;
    wire [15:0] output_macrocell;
    wire [2:0] comb;
    wire asleep;

    // decode entry: index to select number, 17 means not a decode entry
    // port config and array indices come first and shadow two entries
    function [4:0] dec_entry;
        input [7:0] a;
        begin
            if (a >= `MPD_IDX_DEC_BASE && a < `MPD_IDX_DEC_BASE + 8'h22) begin
                dec_entry = a[5:1];
            end else begin
                dec_entry = 5'h11;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // logic input bus
    wire [3:0] strobes = {mcu_ale_i, mcu_cs_n_i, mcu_wr_n_i, mcu_rd_n_i};
    wire [31:0] in_bus_raw = {mcu_addr_i[15:12], strobes, imc_reg};
    wire [31:0] gate_mask = {{4{pwr_b_reg[`MPD_PB_GATE_ADDR]}},
        {4{pwr_b_reg[`MPD_PB_GATE_STROBE]}},
        {24{pwr_b_reg[`MPD_PB_GATE_PORTS]}}};
    // any strobe change counts as bus activity for the power-down timer
    wire bus_active = (strobes != prev_strobe_reg);

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle then acknowledge
    // ack_reg drops waitrequest for one cycle and then forces an idle
    // cycle, so a request held one cycle past the acknowledge is not taken twice
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
            page_reg <= `MPD_RST_PAGE;
            pwr_a_reg <= `MPD_RST_PWR_A;
            pwr_b_reg <= `MPD_RST_PWR_B;
            jtag_en_reg <= `MPD_RST_JTAG_EN;
            port_cfg_reg <= `MPD_RST_PORT_CFG;
            apd_limit_reg <= `MPD_RST_APD_LIMIT;
            match_reg <= {204{1'b0}};
            care_reg <= {204{1'b1}};
            cla_load_reg <= 1'b0;
            cla_load_data_reg <= 16'h0000;
        end else begin
            cla_load_reg <= 1'b0;
            if ((avs_read_i || avs_write_i) && !ack_reg) begin
                ack_reg <= 1'b1;
                avs_waitrequest_o <= 1'b0;
                avs_readdata_o <= 32'h00000000;
                if (avs_write_i) begin
                    if (idx == `MPD_IDX_PAGE) begin
                        page_reg <= avs_writedata_i[7:0];
                    end else if (idx == `MPD_IDX_PWR_A) begin
                        pwr_a_reg <= avs_writedata_i[7:0];
                    end else if (idx == `MPD_IDX_PWR_B) begin
                        pwr_b_reg <= avs_writedata_i[7:0];
                    end else if (idx == `MPD_IDX_JTAG_EN) begin
                        jtag_en_reg <= avs_writedata_i[7:0];
                    end else if (idx == `MPD_IDX_PORT_CFG) begin
                        port_cfg_reg <= avs_writedata_i[7:0];
                    end else if (idx == `MPD_IDX_APD_LIMIT) begin
                        apd_limit_reg <= avs_writedata_i[15:0];
                    end else if (idx == `MPD_IDX_CLA_OUT) begin
                        cla_load_reg <= 1'b1;
                        cla_load_data_reg <= avs_writedata_i[15:0];
                    end else if (dec_entry(idx) != 5'h11) begin
                        if (idx[0]) begin
                            care_reg[dec_entry(idx)*12 +: 12] <=
                                avs_writedata_i[11:0];
                        end else begin
                            match_reg[dec_entry(idx)*12 +: 12] <=
                                avs_writedata_i[11:0];
                        end
                    end
                end else begin
                    if (idx == `MPD_IDX_PAGE) begin
                        avs_readdata_o <= {24'h000000, page_reg};
                    end else if (idx == `MPD_IDX_PWR_A) begin
                        avs_readdata_o <= {24'h000000, pwr_a_reg};
                    end else if (idx == `MPD_IDX_PWR_B) begin
                        avs_readdata_o <= {24'h000000, pwr_b_reg};
                    end else if (idx == `MPD_IDX_JTAG_EN) begin
                        avs_readdata_o <= {24'h000000, jtag_en_reg};
                    end else if (idx == `MPD_IDX_PORT_CFG) begin
                        avs_readdata_o <= {24'h000000, port_cfg_reg};
                    end else if (idx == `MPD_IDX_APD_LIMIT) begin
                        avs_readdata_o <= {16'h0000, apd_limit_reg};
                    end else if (idx == `MPD_IDX_CLA_IN) begin
                        avs_readdata_o <= {8'h00, imc_reg};
                    end else if (idx == `MPD_IDX_CLA_OUT) begin
                        avs_readdata_o <= {13'h0000, comb, output_macrocell};
                    end else if (idx == `MPD_IDX_SELECTS) begin
                        avs_readdata_o <= {15'h0000, dec_sel};
                    end else if (idx == `MPD_IDX_STATUS) begin
                        avs_readdata_o <= {30'h00000000, asleep,
                            powered_down_o};
                    end else if (dec_entry(idx) != 5'h11) begin
                        if (idx[0]) begin
                            avs_readdata_o <= {20'h00000,
                                care_reg[dec_entry(idx)*12 +: 12]};
                        end else begin
                            avs_readdata_o <= {20'h00000,
                                match_reg[dec_entry(idx)*12 +: 12]};
                        end
                    end
                end
            end else begin
                ack_reg <= 1'b0;
                avs_waitrequest_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input macrocells, address latch, input gating, power down
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            imc_reg <= 24'h000000;
            mcu_latch_reg <= 16'h0000;
            // idle strobes: latch low, chip select and strobes high
            prev_strobe_reg <= 4'h7;
            gated_reg <= 32'h00000000;
            apd_cnt_reg <= 16'h0000;
            powered_down_o <= 1'b0;
        end else begin
            imc_reg <= pin_in_i[23:0];
            if (mcu_ale_i) begin
                mcu_latch_reg <= mcu_addr_i;
            end
            prev_strobe_reg <= strobes;
            // gated signals hold their last value
            gated_reg <= (gated_reg & gate_mask)
                | (in_bus_raw & ~gate_mask);
            // the count holds at the limit while powered down
            if (bus_active || !pwr_a_reg[`MPD_PA_APD_EN]) begin
                apd_cnt_reg <= 16'h0000;
                powered_down_o <= 1'b0;
            end else if (apd_cnt_reg >= apd_limit_reg) begin
                powered_down_o <= 1'b1;
            end else begin
                apd_cnt_reg <= apd_cnt_reg + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // arrays
    // powered down looks like chip select high to the decode
    mpd_decode_array u_dec (
        .page_i(page_reg),
        .addr_i(mcu_addr_i),
        .cs_n_i(mcu_cs_n_i | powered_down_o),
        .match_i(match_reg),
        .care_i(care_reg),
        .sel_o(dec_sel)
    );

    mpd_complex_array u_cla (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_bus_i(gated_reg),
        .speed_i(pwr_a_reg[`MPD_PA_SPEED]),
        .load_i(cla_load_reg),
        .load_data_i(cla_load_data_reg),
        .omc_o(output_macrocell),
        .comb_o(comb),
        .asleep_o(asleep)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin muxing and outputs
    wire jtag_on = jtag_en_reg[0];
    wire mcu_rd = ~mcu_rd_n_i & ~mcu_cs_n_i;
    reg [26:0] out_next;
    reg [26:0] oe_next;

    always @* begin
        out_next = {output_macrocell[10:0], output_macrocell};
        oe_next = 27'h0000000;
        oe_next[15:0] = 16'hFFFF;
        // latched low address byte goes out on both ports
        if (port_cfg_reg[`MPD_PC_ADDR_OUT]) begin
            out_next[15:0] = {mcu_latch_reg[7:0], mcu_latch_reg[7:0]};
        end
        if (port_cfg_reg[`MPD_PC_AB_DATA]) begin
            out_next[15:0] = {8'h00, pin_in_i[7:0]};
            oe_next[15:0] = {8'h00, {8{mcu_rd}}};
        end
        if (jtag_on) begin
            out_next[16] = 1'b0;
            out_next[17] = 1'b0;
            out_next[19] = jtag_test_status_out_i;
            out_next[20] = jtag_test_error_out_i;
            out_next[22] = jtag_tdo_i;
            // test_status_out, test_error_out and tdo drive; tms, tck and tdi stay inputs
            oe_next[22:16] = 7'h58;
        end
    end

    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_out_o <= 27'h0000000;
            pin_oe_o <= 27'h0000000;
            jtag_tms_o <= 1'b0;
            jtag_tck_o <= 1'b0;
            jtag_tdi_o <= 1'b0;
            sel_o <= 17'h00000;
            mcu_data_out_o <= 8'h00;
        end else begin
            pin_out_o <= out_next;
            pin_oe_o <= oe_next;
            jtag_tms_o <= jtag_on & pin_in_i[16];
            jtag_tck_o <= jtag_on & pin_in_i[17];
            jtag_tdi_o <= jtag_on & pin_in_i[21];
            sel_o <= dec_sel;
            mcu_data_out_o <= pin_in_i[7:0];
        end
    end
endmodule // mpd_top
`default_nettype wire

// ==== verification/mpd_top_assertions.sv ====
// port-level assertions for the peripheral top
`timescale 1ns/1ps
`default_nettype none
module mpd_top_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // avalon side
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    // microcontroller side
    input wire logic mcu_rd_n_i,
    input wire logic mcu_wr_n_i,
    input wire logic mcu_cs_n_i,
    input wire logic [26:0] pin_in_i,
    // results
    input wire logic [16:0] sel_o,
    input wire logic powered_down_o,
    input wire logic [7:0] mcu_data_out_o
);
default clocking cb @(posedge clk_i);
endclocking
default disable iff (rst_i);
wire req;
assign req = avs_read_i | avs_write_i;
////////////////////////////////////////////////////////////////////////////
wait_answer_a: assert property (
    $rose(req) |-> ##[1:2] !avs_waitrequest_o)
    else $error("no answer to register access");
wait_pulse_a: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
wait_cause_a: assert property (
    !avs_waitrequest_o |-> req && $past(req))
    else $error("waitrequest low without a request");
read_hold_a: assert property (
    !req && !$past(req) |-> $stable(avs_readdata_o))
    else $error("read data moved while idle");
cs_off_a: assert property (
    mcu_cs_n_i |=> sel_o == 17'h00000)
    else $error("select active while chip select high");
pd_sel_a: assert property (
    powered_down_o && $past(powered_down_o) |-> sel_o == 17'h00000)
    else $error("select active while powered down");
port_copy_a: assert property (
    1'b1 |=> mcu_data_out_o == $past(pin_in_i[7:0]))
    else $error("port a copy wrong");
strobe_wake_a: assert property (
    powered_down_o && ($changed(mcu_rd_n_i) || $changed(mcu_wr_n_i)
    || $changed(mcu_cs_n_i)) |-> ##[1:4] !powered_down_o)
    else $error("no wake on strobe");
cover property (avs_read_i && !avs_waitrequest_o);
cover property (powered_down_o);
cover property (sel_o != 17'h00000);
cover property (powered_down_o ##1 !powered_down_o);
endmodule // mpd_top_chk
bind mpd_top mpd_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .mcu_rd_n_i(mcu_rd_n_i), .mcu_wr_n_i(mcu_wr_n_i),
    .mcu_cs_n_i(mcu_cs_n_i), .pin_in_i(pin_in_i), .sel_o(sel_o),
    .powered_down_o(powered_down_o), .mcu_data_out_o(mcu_data_out_o));
`default_nettype wire

// ==== verification/mpd_mcu_model.sv ====
// behavioural microcontroller bus and port pin model
`timescale 1ns/1ps
`default_nettype none
module mpd_mcu_model (
    // clock
    input wire logic clk_i,
    // microcontroller bus
    output logic [15:0] addr_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic ale_o,
    output logic cs_n_o,
    // port pins
    output logic [26:0] pin_o
);
initial begin
    addr_o = 16'hFFFF;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    ale_o = 1'b0;
    cs_n_o = 1'b1;
    pin_o = 27'h0;
end
task automatic select(input logic cs_n, input logic [15:0] a);
    @(posedge clk_i);
    cs_n_o <= cs_n;
    addr_o <= a;
endtask
// address latch pulse then one read strobe; address flips once released
task automatic read_cycle(input logic [15:0] a);
    @(posedge clk_i);
    addr_o <= a;
    ale_o <= 1'b1;
    @(posedge clk_i);
    ale_o <= 1'b0;
    rd_n_o <= 1'b0;
    @(posedge clk_i);
    rd_n_o <= 1'b1;
    addr_o <= ~a;
endtask
task automatic pins(input logic [26:0] v);
    @(posedge clk_i);
    pin_o <= v;
endtask
endmodule // mpd_mcu_model
`default_nettype wire

// ==== verification/mpd_top_bench.sv ====
// self-checking bench for the peripheral top
`timescale 1ns/1ps
`default_nettype none
`include "mpd_map.vh"
module mpd_top_bench;
logic clk_i, rst_i, rd, wr, rd_n, wr_n, ale, cs_n;
logic tdo, test_status_out, test_error_out, tms, tck, tdi, wait_o, pd;
logic [9:0] adr;
logic [31:0] wdat, rdat, rdo;
logic [15:0] maddr;
logic [26:0] pin_in, pin_out, pin_oe;
logic [16:0] sel;
logic [7:0] mdo;
int num_errors = 0;
int samples_checked = 0;
mpd_mcu_model mcu (.clk_i(clk_i), .addr_o(maddr), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .ale_o(ale), .cs_n_o(cs_n), .pin_o(pin_in));
mpd_top dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdo), .avs_waitrequest_o(wait_o), .mcu_addr_i(maddr),
    .mcu_rd_n_i(rd_n), .mcu_wr_n_i(wr_n), .mcu_ale_i(ale),
    .mcu_cs_n_i(cs_n), .pin_in_i(pin_in), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe), .jtag_tdo_i(tdo), .jtag_test_status_out_i(test_status_out),
    .jtag_test_error_out_i(test_error_out), .jtag_tms_o(tms), .jtag_tck_o(tck),
    .jtag_tdi_o(tdi), .sel_o(sel), .powered_down_o(pd),
    .mcu_data_out_o(mdo));
////////////////////////////////////////////////////////////////////////////
task automatic print_verdict();
    $display("compares %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
        $display("All tests passed");
    end else begin
        $display("Some tests failed");
    end
    $finish;
endtask
task automatic check(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
        num_errors++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
endtask
// one avalon access; holds the request until waitrequest is seen low
task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= {idx, 2'b00};
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
        @(posedge clk_i);
        n++;
    end while (wait_o !== 1'b0 && n < 50);
    if (n >= 50) begin
        num_errors++;
        print_verdict();
    end
    rdat = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
endtask
////////////////////////////////////////////////////////////////////////////
task automatic t_reset();
    bus(0, `MPD_IDX_PAGE, 0);
    check(32'h00, rdat);
    bus(0, `MPD_IDX_PWR_A, 0);
    check(32'h01, rdat);
    bus(0, `MPD_IDX_PWR_B, 0);
    check(32'h00, rdat);
    bus(0, `MPD_IDX_APD_LIMIT, 0);
    check(32'h0100, rdat);
    bus(1, 8'h10, 32'hFF);
    bus(0, 8'h10, 0);
    check(32'h0, rdat);
endtask
task automatic t_decode();
    mcu.select(1'b0, 16'h0123);
    repeat (3) @(posedge clk_i);
    check(32'h1FFFF, {15'h0, sel});
    bus(1, `MPD_IDX_PAGE, 32'h01);
    bus(0, `MPD_IDX_PAGE, 0);
    check(32'h01, rdat);
    repeat (3) @(posedge clk_i);
    check(32'h0, {15'h0, sel});
    bus(1, 8'h47, 0);
    bus(1, 8'h53, 0);
    repeat (3) @(posedge clk_i);
    check(32'h00208, {15'h0, sel});
    mcu.select(1'b1, 16'h0123);
    repeat (3) @(posedge clk_i);
    check(32'h0, {15'h0, sel});
endtask
task automatic t_ports();
    mcu.pins(27'h02300A5);
    tdo <= 1'b1;
    bus(1, `MPD_IDX_JTAG_EN, 32'h01);
    repeat (3) @(posedge clk_i);
    check(32'h7, {29'h0, tms, tck, tdi});
    check(32'h1, {31'h0, pin_out[22]});
    check(32'hA5, {24'h0, mdo});
    check(32'h58, {25'h0, pin_oe[22:16]});
    bus(1, `MPD_IDX_JTAG_EN, 32'h00);
    repeat (3) @(posedge clk_i);
    check(32'h0, {29'h0, tms, tck, tdi});
    bus(1, `MPD_IDX_PORT_CFG, 32'h01);
    repeat (3) @(posedge clk_i);
    check(32'h0, {16'h0, pin_oe[15:0]});
    bus(1, `MPD_IDX_PORT_CFG, 32'h00);
endtask
task automatic t_sleep();
    bus(1, `MPD_IDX_PWR_A, 32'h00);
    repeat (3) @(posedge clk_i);
    bus(0, `MPD_IDX_STATUS, 0);
    check(32'h1, {31'h0, rdat[1]});
    bus(1, `MPD_IDX_CLA_OUT, 32'h1234);
    bus(0, `MPD_IDX_CLA_OUT, 0);
    check(32'h1234, {16'h0, rdat[15:0]});
    bus(1, `MPD_IDX_PWR_A, 32'h01);
endtask
task automatic t_gate();
    logic [31:0] held;
    bus(1, `MPD_IDX_PWR_B, 32'h02);
    bus(0, `MPD_IDX_CLA_OUT, 0);
    held = rdat;
    mcu.pins(27'h0000000);
    repeat (3) @(posedge clk_i);
    bus(0, `MPD_IDX_CLA_OUT, 0);
    check(held, rdat);
    bus(1, `MPD_IDX_PWR_B, 32'h00);
endtask
task automatic t_apd();
    int n;
    mcu.select(1'b0, 16'h0123);
    bus(1, `MPD_IDX_APD_LIMIT, 32'h10);
    bus(1, `MPD_IDX_PWR_A, 32'h03);
    for (n = 0; n < 300 && pd !== 1'b1; n++) begin
        @(posedge clk_i);
    end
    check(32'h1, {31'h0, pd});
    repeat (2) @(posedge clk_i);
    check(32'h0, {15'h0, sel});
    mcu.select(1'b1, 16'h0123);
    repeat (2) @(posedge clk_i);
    check(32'h0, {31'h0, pd});
    for (n = 0; n < 300 && pd !== 1'b1; n++) begin
        @(posedge clk_i);
    end
    check(32'h1, {31'h0, pd});
    mcu.read_cycle(16'h0040);
    repeat (4) @(posedge clk_i);
    check(32'h0, {31'h0, pd});
endtask
////////////////////////////////////////////////////////////////////////////
initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
end
initial begin
    rst_i = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 10'h0;
    wdat = 32'h0;
    tdo = 1'b0;
    test_status_out = 1'b0;
    test_error_out = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_decode();
    t_ports();
    t_sleep();
    t_gate();
    t_apd();
    print_verdict();
end
endmodule // mpd_top_bench
`default_nettype wire
